// ---- verilog/gfc_pkg.sv ----
package gfc_pkg;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned TIMEOUT_MS = 1000;
  localparam int unsigned TIMEOUT_CYCLES =
    (CLK_HZ / 1000) * TIMEOUT_MS;
  localparam int TMR_W = 24;

  // ***************************************************************
  // Codes and group states
  // ***************************************************************
  localparam logic [31:0] OPTION_ALLOWED = 32'h0000_0000;
  localparam logic [15:0] CODE_NONE = 16'h0000;
  localparam logic [15:0] CODE_OPTION_RANGE = 16'h1a4e;
  localparam logic [7:0] GROUP_HALTED_ON_FAULT = 8'h01;

  // ***************************************************************
  // Register map (byte addresses)
  // ***************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] ADDR_CODE = 8'h10;

  // Field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int EV_DONE_BIT = 0;
  localparam int EV_ABORT_BIT = 1;
  localparam int EV_ERROR_BIT = 2;
  localparam int EV_W = 3;

  // Reset values
  localparam logic CTRL_RESET = 1'b1;
  localparam logic [EV_W-1:0] IRQ_MASK_RESET = 3'h0;

  // ***************************************************************
  // Sequencer states
  // ***************************************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RUN,
    ST_DONE,
    ST_ABORT,
    ST_ERROR
  } gfc_state_type;

endpackage : gfc_pkg

// ---- verilog/gfc_timer_if.sv ----
`timescale 1ns/1ps
interface gfc_timer_if;
  logic run;
  logic expired;

  // Sequencer side
  modport ctrl (output run, input expired);
  // Timer side
  modport tmr (input run, output expired);
endinterface : gfc_timer_if

// ---- verilog/gfc_edge_detect.sv ----
`timescale 1ns/1ps
module gfc_edge_detect (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hclk_en,
  // Level in, pulse out
  input wire logic level_in,
  output logic rise
);

  logic prev_reg;
  logic prev_next;

  // Previous level, frozen with the clock enable
  always_comb begin
    prev_next = hclk_en ? level_in : prev_reg;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
    end
  end

  // A level held high after reset does not count as an edge twice
  assign rise = level_in & ~prev_reg;

endmodule : gfc_edge_detect

// ---- verilog/gfc_timeout_timer.sv ----
`timescale 1ns/1ps
module gfc_timeout_timer #(
  parameter int unsigned LIMIT = gfc_pkg::TIMEOUT_CYCLES
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hclk_en,
  // Sequencer link
  gfc_timer_if.tmr tif
);
  import gfc_pkg::*;

  localparam logic [TMR_W-1:0] LAST = TMR_W'(LIMIT - 1);

  logic [TMR_W-1:0] cnt_reg;
  logic [TMR_W-1:0] cnt_next;
  logic exp_reg;
  logic exp_next;

  // Count while running, clear when idle; expiry stays until run drops
  always_comb begin
    cnt_next = cnt_reg;
    exp_next = exp_reg;
    if (hclk_en) begin
      if (!tif.run) begin
        cnt_next = '0;
        exp_next = 1'b0;
      end else if (cnt_reg == LAST) begin
        exp_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + TMR_W'(1);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= '0;
      exp_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      exp_reg <= exp_next;
    end
  end

  assign tif.expired = exp_reg;

endmodule : gfc_timeout_timer

// ---- verilog/gfc_group_fault_clear_block.sv ----
// Operation
// R1 - A clear starts only on a rising edge of the start request.
// R2 - On start, busy and the group fault-clear request go high.
// R3 - When errors and warnings are cleared, busy drops and done rises.
// R4 - If the group is not halted on fault, clearing warnings gives done.
// R5 - Uncleared after one second, abort rises and the request drops.
// R6 - Abort stays high until the start request goes low.
// R7 - A nonzero option word gives error with code 1a4e.
// R8 - Any error raises the error flag with its 16-bit code.
// R9 - The controller never drives the group clear request itself.
// R10 - After abort the controller drops start, fixes causes, retries.
// R11 - Done, abort or error hold until start drops, then all clear.
// R12 - Start is edge detected; the timer is sized for one second.
`timescale 1ns/1ps
module gfc_group_fault_clear_block #(
  parameter int unsigned TIMEOUT_CYCLES = gfc_pkg::TIMEOUT_CYCLES
) (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hclk_en,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Commanding controller
  input wire logic start_request,
  input wire logic [31:0] option_word,
  output logic busy,
  output logic done,
  output logic abort_flag,
  output logic error_flag,
  output logic [15:0] fault_code,
  // Motion axes group
  input wire logic [7:0] group_state,
  input wire logic group_faults_cleared,
  input wire logic group_warnings_cleared,
  input wire logic group_error_valid,
  input wire logic [15:0] group_error_code,
  output logic group_fault_clear_request,
  // Interrupt
  output logic irq
);
  import gfc_pkg::*;

  // ***************************************************************
  // Helpers
  // ***************************************************************
  gfc_timer_if tif ();
  logic start_rise;

  gfc_edge_detect u_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .hclk_en(hclk_en),
    .level_in(start_request),
    .rise(start_rise) // R12
  );

  gfc_timeout_timer #(
    .LIMIT(TIMEOUT_CYCLES) // R12
  ) u_tmr (
    .hclk(hclk),
    .hresetn(hresetn),
    .hclk_en(hclk_en),
    .tif(tif)
  );

  // ***************************************************************
  // Sequencer
  // ***************************************************************
  gfc_state_type state_reg;
  gfc_state_type state_next;
  logic [15:0] code_reg;
  logic [15:0] code_next;
  logic enable_reg;
  logic cleared;

  // Halted groups need real fault clearing; otherwise warnings suffice
  assign cleared = (group_state == GROUP_HALTED_ON_FAULT) ?
                   group_faults_cleared : group_warnings_cleared; // R4

  // Timer runs only while the clear is in progress
  assign tif.run = (state_reg == ST_RUN); // R5

  // Next state; an external error outranks completion and timeout
  always_comb begin
    state_next = state_reg;
    code_next = code_reg;
    if (hclk_en) begin
      case (state_reg)
        ST_IDLE: begin
          if (start_rise && enable_reg) begin // R1
            if (option_word != OPTION_ALLOWED) begin
              state_next = ST_ERROR; // R7
              code_next = CODE_OPTION_RANGE; // R7
            end else begin
              state_next = ST_RUN; // R2
            end
          end
        end
        ST_RUN: begin
          if (group_error_valid) begin
            state_next = ST_ERROR; // R8
            code_next = group_error_code; // R8
          end else if (cleared) begin
            state_next = ST_DONE; // R3
          end else if (tif.expired) begin
            state_next = ST_ABORT; // R5
          end
        end
        ST_DONE, ST_ABORT, ST_ERROR: begin
          if (!start_request) begin // R6 R11
            state_next = ST_IDLE;
            code_next = CODE_NONE; // R11
          end
        end
        default: begin
          state_next = ST_IDLE;
          code_next = CODE_NONE;
        end
      endcase
    end
  end

  // Outputs are registered from the next state so they leave flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_IDLE;
      code_reg <= CODE_NONE;
      busy <= 1'b0;
      done <= 1'b0;
      abort_flag <= 1'b0;
      error_flag <= 1'b0;
      fault_code <= CODE_NONE;
      group_fault_clear_request <= 1'b0;
    end else begin
      state_reg <= state_next;
      code_reg <= code_next;
      busy <= (state_next == ST_RUN); // R2
      done <= (state_next == ST_DONE); // R3
      abort_flag <= (state_next == ST_ABORT); // R6
      error_flag <= (state_next == ST_ERROR); // R8
      fault_code <= code_next; // R8
      group_fault_clear_request <= (state_next == ST_RUN); // R2 R5 R9
    end
  end

  // ***************************************************************
  // Bus slave and registers
  // ***************************************************************
  logic accept;
  logic wr_pend_reg;
  logic wr_pend_next;
  logic [7:0] wr_addr_reg;
  logic [7:0] wr_addr_next;
  logic [31:0] rd_data;
  logic [31:0] hrdata_next;
  logic enable_next;
  logic [EV_W-1:0] mask_reg;
  logic [EV_W-1:0] mask_next;
  logic [EV_W-1:0] stat_reg;
  logic [EV_W-1:0] stat_next;
  logic [EV_W-1:0] events;
  logic irq_next;

  assign accept = hsel && htrans[1] && hready;

  // Entry into a final state, one pulse per operation
  assign events[EV_DONE_BIT] = hclk_en && state_reg != ST_DONE &&
                               state_next == ST_DONE;
  assign events[EV_ABORT_BIT] = hclk_en && state_reg != ST_ABORT &&
                                state_next == ST_ABORT;
  assign events[EV_ERROR_BIT] = hclk_en && state_reg != ST_ERROR &&
                                state_next == ST_ERROR;

  // Read mux; unmapped addresses read zero
  always_comb begin
    case (haddr[7:0])
      ADDR_CTRL: rd_data = {31'h0, enable_reg};
      ADDR_STATUS: rd_data = {27'h0, error_flag, abort_flag, done,
                              busy, group_fault_clear_request};
      ADDR_IRQ_STAT: rd_data = {29'h0, stat_reg};
      ADDR_IRQ_MASK: rd_data = {29'h0, mask_reg};
      ADDR_CODE: rd_data = {16'h0, fault_code};
      default: rd_data = 32'h0;
    endcase
  end

  // Zero wait state: read data is latched at the address phase edge
  always_comb begin
    wr_pend_next = wr_pend_reg;
    wr_addr_next = wr_addr_reg;
    hrdata_next = hrdata;
    enable_next = enable_reg;
    mask_next = mask_reg;
    stat_next = stat_reg;
    irq_next = irq;
    if (hclk_en) begin
      wr_pend_next = accept && hwrite;
      wr_addr_next = haddr[7:0];
      if (accept && !hwrite) begin
        hrdata_next = rd_data;
      end
      if (wr_pend_reg && wr_addr_reg == ADDR_CTRL) begin
        enable_next = hwdata[CTRL_ENABLE_BIT];
      end
      if (wr_pend_reg && wr_addr_reg == ADDR_IRQ_MASK) begin
        mask_next = hwdata[EV_W-1:0];
      end
      // Read clears, but a same-cycle event still lands
      if (accept && !hwrite && haddr[7:0] == ADDR_IRQ_STAT) begin
        stat_next = '0;
      end
      stat_next = stat_next | events;
      irq_next = |(stat_next & mask_next);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata <= 32'h0;
      enable_reg <= CTRL_RESET;
      mask_reg <= IRQ_MASK_RESET;
      stat_reg <= '0;
      irq <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      hrdata <= hrdata_next;
      enable_reg <= enable_next;
      mask_reg <= mask_next;
      stat_reg <= stat_next;
      irq <= irq_next;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge hclk iff hclk_en);
  endclocking
  default disable iff (!hresetn);

  a_busy_from_edge: assert property ( // R1
    $rose(busy) |-> $past(start_rise) && $past(enable_reg))
    else $error("busy rose without a start edge");

  a_busy_drives_req: assert property ( // R2
    busy |-> group_fault_clear_request && !done && !abort_flag)
    else $error("busy without the clear request");

  a_clear_gives_done: assert property ( // R3
    state_reg == ST_RUN && !group_error_valid &&
    group_state == GROUP_HALTED_ON_FAULT && group_faults_cleared
    |=> done && !busy)
    else $error("cleared faults did not give done");

  a_warn_only_done: assert property ( // R4
    state_reg == ST_RUN && !group_error_valid &&
    group_state != GROUP_HALTED_ON_FAULT && group_warnings_cleared
    |=> done && !busy)
    else $error("warning clear did not give done");

  a_timeout_abort: assert property ( // R5
    state_reg == ST_RUN && tif.expired && !cleared &&
    !group_error_valid
    |=> abort_flag && !group_fault_clear_request && !busy)
    else $error("timeout did not abort");

  a_abort_holds: assert property ( // R6
    abort_flag && start_request |=> abort_flag)
    else $error("abort dropped while start high");

  a_option_error: assert property ( // R7
    state_reg == ST_IDLE && start_rise && enable_reg &&
    option_word != OPTION_ALLOWED
    |=> error_flag && fault_code == CODE_OPTION_RANGE && !busy)
    else $error("bad option not reported");

  a_group_error: assert property ( // R8
    state_reg == ST_RUN && group_error_valid
    |=> error_flag && fault_code == $past(group_error_code))
    else $error("group error code not reported");

  a_release_clears: assert property ( // R11
    (done || abort_flag || error_flag) && !start_request
    |=> !done && !abort_flag && !error_flag && !busy &&
        fault_code == CODE_NONE)
    else $error("outputs not cleared on release");

  c_normal_done: cover property (busy ##[1:20] done);
  c_timeout: cover property (busy ##1 busy [*3] ##[1:1000] abort_flag);
  c_option_err: cover property (error_flag &&
    fault_code == CODE_OPTION_RANGE);
  c_irq: cover property ($rose(irq));

endmodule : gfc_group_fault_clear_block

// ---- verif/gfc_group_model.sv ----
`timescale 1ns/1ps
// Behavioural axes group on the far side of the clear request
module gfc_group_model #(
  parameter logic [15:0] ERR_CODE = 16'h0b2c
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Scenario controls
  input wire logic halted,
  input wire logic cause,
  input wire logic err_inj,
  input wire logic [3:0] dly,
  // Group side
  input wire logic group_fault_clear_request,
  output logic [7:0] group_state,
  output logic group_faults_cleared,
  output logic group_warnings_cleared,
  output logic group_error_valid,
  output logic [15:0] group_error_code
);
  logic [3:0] cnt_reg;
  logic ripe;
  // Cycles since the request rose; only the sequencer raises it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cnt_reg <= 4'h0;
    else if (!group_fault_clear_request) cnt_reg <= 4'h0;
    else if (cnt_reg != 4'hf) cnt_reg <= cnt_reg + 4'h1;
  end
  // Slow or prompt answer; a standing cause blocks the fault clear
  assign ripe = group_fault_clear_request && (cnt_reg >= dly);
  assign group_state = halted ? 8'h01 : 8'h03;
  assign group_warnings_cleared = ripe;
  assign group_faults_cleared = ripe && !cause;
  assign group_error_valid = ripe && err_inj;
  // Code means nothing without valid, so it shows a wrong pattern
  assign group_error_code = group_error_valid ? ERR_CODE : ~ERR_CODE;
endmodule : gfc_group_model

// ---- verif/tb.sv ----
`timescale 1ns/1ps
module tb;
  import gfc_pkg::*;
  localparam int unsigned TMO = 20;
  localparam logic [15:0] GERR = 16'h0b2c;
  logic hclk, hresetn, hsel, hwrite, start_request, hclk_en;
  logic halted, cause, err_inj, hreadyout, hresp;
  logic busy, done, abort_flag, error_flag, irq, gfcr;
  logic gfc, gwc, gev;
  logic [31:0] haddr, hwdata, option_word, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] dly;
  logic [7:0] gst;
  logic [15:0] fault_code, gcode;
  int err_count = 0;
  int n_tests = 0;
  int n;
  gfc_group_fault_clear_block #(.TIMEOUT_CYCLES(TMO)) dut (
    .hclk(hclk), .hresetn(hresetn), .hclk_en(hclk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .start_request(start_request),
    .option_word(option_word), .busy(busy), .done(done),
    .abort_flag(abort_flag), .error_flag(error_flag),
    .fault_code(fault_code), .group_state(gst),
    .group_faults_cleared(gfc), .group_warnings_cleared(gwc),
    .group_error_valid(gev), .group_error_code(gcode),
    .group_fault_clear_request(gfcr), .irq(irq));
  gfc_group_model #(.ERR_CODE(GERR)) grp (
    .hclk(hclk), .hresetn(hresetn), .halted(halted), .cause(cause),
    .err_inj(err_inj), .dly(dly), .group_fault_clear_request(gfcr),
    .group_state(gst), .group_faults_cleared(gfc),
    .group_warnings_cleared(gwc), .group_error_valid(gev),
    .group_error_code(gcode));
  // ***************************************************************
  // Tasks
  // ***************************************************************
  task automatic finish_test;
    $display("errors %0d, checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk
  // Busy, done, abort, error, request as one word
  function automatic logic [31:0] st();
    return {27'h0, busy, done, abort_flag, error_flag, gfcr};
  endfunction : st
  // Single word transfer; waits on hready, no fixed latency assumed
  task automatic ahb(input logic w, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    #1;
  endtask : ahb
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
      input string nm);
    logic [31:0] d;
    ahb(1'b0, a, 32'h0, d);
    chk(nm, e, d);
  endtask : rdc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask : wr
  // Rising start edge; returns just after the edge that takes it
  task automatic go(input logic [31:0] opt);
    @(posedge hclk);
    option_word <= opt;
    start_request <= 1'b1;
    @(posedge hclk);
    #1;
  endtask : go
  // Cycles until a final state, bounded
  task automatic fin(output int c);
    c = 0;
    while (!(done | abort_flag | error_flag) && c < 60) begin
      @(posedge hclk);
      #1;
      c++;
    end
  endtask : fin
  task automatic hold(input logic [31:0] e);
    repeat (3) @(posedge hclk);
    #1;
    chk("held result", e, st());
  endtask : hold
  task automatic stop;
    @(posedge hclk);
    start_request <= 1'b0;
    option_word <= 32'h0;
    repeat (2) @(posedge hclk);
    #1;
    chk("released", 32'h0, st() | {16'h0, fault_code});
  endtask : stop
  // ***************************************************************
  // Scenarios
  // ***************************************************************
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  // Whole run is under two hundred cycles
  initial begin
    repeat (5000) @(posedge hclk);
    err_count++;
    finish_test;
  end
  initial begin
    {hresetn, hsel, hwrite, start_request, err_inj} = 5'h0;
    {halted, cause, haddr, hwdata, option_word, htrans} = '0;
    hclk_en = 1'b1;
    hsize = 3'h2;
    dly = 4'h4;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    chk("reset outputs", 32'h1,
        (st() << 3) | {29'h0, irq, hresp, hreadyout});
    rdc(ADDR_CTRL, 32'h1, "ctrl reset");
    rdc(ADDR_IRQ_MASK, 32'h0, "mask reset");
    rdc(8'h20, 32'h0, "unmapped");
    wr(ADDR_IRQ_MASK, 32'h7);
    // Not halted, cause standing: warnings alone finish it
    cause <= 1'b1;
    go(32'h0);
    chk("busy and request", 32'h11, st());
    fin(n);
    chk("done", 32'h8, st());
    hold(32'h8);
    chk("irq", 32'h1, {31'h0, irq});
    rdc(ADDR_IRQ_STAT, 32'h1 << EV_DONE_BIT, "done event");
    chk("irq cleared", 32'h0, {31'h0, irq});
    stop;
    // Disabled start, then a steady high level after enabling
    wr(ADDR_CTRL, 32'h0);
    go(32'h0);
    wr(ADDR_CTRL, 32'h1);
    hold(32'h0);
    stop;
    // Halted with a standing cause: timeout
    halted <= 1'b1;
    go(32'h0);
    fin(n);
    chk("timeout cycles", TMO + 1, n);
    chk("abort", 32'h4, st());
    hold(32'h4);
    rdc(ADDR_IRQ_STAT, 32'h1 << EV_ABORT_BIT, "abort event");
    stop;
    cause <= 1'b0;
    go(32'h0);
    // Enable low freezes the run although the group is ready
    hclk_en <= 1'b0;
    repeat (8) @(posedge hclk);
    #1;
    chk("frozen run", 32'h11, st());
    hclk_en <= 1'b1;
    fin(n);
    chk("retry done", 32'h8, st());
    rdc(ADDR_IRQ_STAT, 32'h1 << EV_DONE_BIT, "retry event");
    stop;
    // Nonzero options, with the interrupt masked
    wr(ADDR_IRQ_MASK, 32'h0);
    for (int i = 0; i < 32; i += 31) begin
      go(32'h1 << i);
      chk("option error", 32'h2, st());
      chk("option code", {16'h0, CODE_OPTION_RANGE},
          {16'h0, fault_code});
      rdc(ADDR_CODE, {16'h0, CODE_OPTION_RANGE}, "code reg");
      stop;
    end
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(ADDR_IRQ_MASK, 32'h7);
    @(posedge hclk);
    #1;
    chk("irq unmasked", 32'h1, {31'h0, irq});
    rdc(ADDR_IRQ_STAT, 32'h1 << EV_ERROR_BIT, "error event");
    // Slow group reporting an error of its own
    err_inj <= 1'b1;
    dly <= 4'hf;
    go(32'h0);
    rdc(ADDR_STATUS, 32'h3, "status busy");
    fin(n);
    chk("group error", 32'h2, st());
    chk("group code", {16'h0, GERR}, {16'h0, fault_code});
    stop;
    finish_test;
  end
endmodule : tb
